// *** logic/pcr_pin_cell.sv ***
// One pad cell: input style, output drive type, pull resistor selection
`timescale 1ns/100ps
module pcr_pin_cell
  import pcr_pkg::*;
#(
  parameter bit INPUT_ONLY = 1'b0
) (
  // Clock and logic reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ready,
  // Configuration
  input  wire logic [CFG_W-1:0] cfg,
  // Core side
  input  wire logic             core_out,
  input  wire logic             core_oe,
  output logic                  core_in,
  // Pad side
  input  wire logic             pad_in,
  output logic                  pad_out,
  output logic                  pad_oe,
  output logic                  pull_en,
  output logic                  pull_up,
  output logic [1:0]            pull_val,
  output logic                  drive2x,
  output logic [1:0]            in_style
);

  typedef struct packed {
    logic in_q;
    logic in_prev;
    logic o;
    logic oe;
  } pcr_cell_s;

  pcr_cell_s cur;
  pcr_cell_s next_cur;
  pcr_sel_e  sel;
  logic      drive;
  logic      unused;

  always_comb begin
    sel      = pcr_sel(cfg);
    unused   = (sel == SEL_NONE);
    drive    = !INPUT_ONLY && ((sel == SEL_OUT) || ((sel == SEL_INOUT) && core_oe)); // R14
    next_cur = cur;
    next_cur.in_prev = pad_in;
    // Hysteresis modelled as two agreeing samples before the level moves
    if (cfg[F_INS +: 2] != INS_SCHMITT || pad_in == cur.in_prev) begin // R02
      next_cur.in_q = pad_in;
    end
    case (pcr_drv(cfg)) // R03
      DRV_OD_LOW: begin
        next_cur.o  = 1'b0;
        next_cur.oe = drive && !core_out;
      end
      DRV_OD_HIGH: begin
        next_cur.o  = 1'b1;
        next_cur.oe = drive && core_out;
      end
      default: begin
        next_cur.o  = core_out;
        next_cur.oe = drive;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // No drive enable or pull enable reaches the pad before the power-on sequence ends
  assign pad_out  = cur.o;
  // Mode gate keeps a stale enable off the pad in the cycle an input or unused mode lands
  assign pad_oe   = cur.oe && ready && (sel == SEL_OUT || sel == SEL_INOUT); // R07 R14 R06
  assign core_in  = cur.in_q && ready && (sel == SEL_IN || sel == SEL_INOUT);
  assign pull_en  = ready && (unused || cfg[F_PEN]); // R05 R06
  assign pull_up  = !unused && !INPUT_ONLY && cfg[F_PUP];
  assign pull_val = unused ? PV_1M : cfg[F_PVAL +: 2];
  assign drive2x  = cfg[F_STR];
  assign in_style = cfg[F_INS +: 2];

endmodule : pcr_pin_cell

// *** logic/pcr_pkg.sv ***
// Shared constants, types and field helpers for the pin configuration block
package pcr_pkg;

  // Clock and power-on sequence timing
  localparam int CLK_NS  = 10;
  localparam int POR_NS  = 1000;
  localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W   = 8;
  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_MAX  = 8'hFF;

  // Pins: index 0 is the input-only pin, index 1 the clock-capable pin
  localparam int NPIN    = 6;
  localparam int PIN_IN  = 0;
  localparam int PIN_CLK = 1;

  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_PIN0 = 4'h0;
  localparam logic [ADDR_W-1:0] REG_RST  = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h7;

  // Per-pin configuration word
  localparam int CFG_W  = 16;
  localparam int F_SEL  = 0;
  localparam int F_INS  = 2;
  localparam int F_DRV  = 4;
  localparam int F_STR  = 6;
  localparam int F_PEN  = 7;
  localparam int F_PUP  = 8;
  localparam int F_PVAL = 9;
  localparam int F_CLK  = 11;
  // Unused pin, 1M pull-down enabled
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0480;

  // External reset configuration word
  localparam int RCFG_W  = 3;
  localparam int F_RMODE = 0;
  localparam int F_REDGE = 2;
  localparam logic [RCFG_W-1:0] RCFG_RST = 3'h0;

  // Status word bit positions
  localparam int S_READY = 0;
  localparam int S_CLK   = 1;
  localparam int S_IN    = 8;

  typedef enum logic [1:0] {SEL_NONE, SEL_IN, SEL_OUT, SEL_INOUT} pcr_sel_e;
  typedef enum logic [1:0] {INS_PLAIN, INS_SCHMITT, INS_LOWV} pcr_ins_e;
  typedef enum logic [1:0] {DRV_PP, DRV_OD_LOW, DRV_OD_HIGH} pcr_drv_e;
  typedef enum logic [1:0] {PV_10K, PV_100K, PV_1M} pcr_pval_e;
  typedef enum logic [1:0] {RM_OFF, RM_LEVEL, RM_EDGE} pcr_rmode_e;
  typedef enum logic [1:0] {ST_HOLD, ST_SEQ, ST_RUN} pcr_rst_st_e;

  function automatic pcr_sel_e pcr_sel(input logic [CFG_W-1:0] cfg);
    return pcr_sel_e'(cfg[F_SEL +: 2]);
  endfunction : pcr_sel

  function automatic pcr_drv_e pcr_drv(input logic [CFG_W-1:0] cfg);
    return pcr_drv_e'(cfg[F_DRV +: 2]);
  endfunction : pcr_drv

  function automatic pcr_rmode_e pcr_rmode(input logic [RCFG_W-1:0] rcfg);
    return pcr_rmode_e'(rcfg[F_RMODE +: 2]);
  endfunction : pcr_rmode

endpackage : pcr_pkg

// *** logic/pcr_rst_ctrl.sv ***
// External reset detector and power-on sequence counter
`timescale 1ns/100ps
module pcr_rst_ctrl
  import pcr_pkg::*;
(
  // Clock and chip reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Control
  input  wire logic              gpi,
  input  wire logic [RCFG_W-1:0] rcfg,
  // Result
  output logic                   ready
);

  typedef struct packed {
    logic              gpi_q;
    logic              gpi_prev;
    logic [CNT_W-1:0]  cnt;
    pcr_rst_st_e       st;
  } pcr_rst_s;

  pcr_rst_s   cur;
  pcr_rst_s   next_cur;
  pcr_rmode_e mode;
  logic       edge_hit;

  always_comb begin
    mode     = pcr_rmode(rcfg);
    edge_hit = rcfg[F_REDGE] ? (cur.gpi_q && !cur.gpi_prev)
                             : (!cur.gpi_q && cur.gpi_prev); // R12
    next_cur = cur;
    next_cur.gpi_q    = gpi;
    next_cur.gpi_prev = cur.gpi_q;
    case (cur.st)
      ST_HOLD: begin
        next_cur.st  = ST_SEQ; // R11
        next_cur.cnt = '0;
      end
      ST_SEQ: begin
        if (cur.cnt == POR_LAST) begin
          next_cur.st = ST_RUN;
        end else begin
          next_cur.cnt = cur.cnt + CNT_W'(1);
        end
      end
      default: begin
        next_cur.st = ST_RUN;
      end
    endcase
    if (mode == RM_LEVEL && cur.gpi_q) begin // R09 R10
      next_cur.st = ST_HOLD;
    end else if (mode == RM_EDGE && edge_hit) begin // R13
      next_cur.st  = ST_SEQ;
      next_cur.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '{gpi_q: 1'b0, gpi_prev: 1'b0, cnt: '0, st: ST_SEQ};
    end else begin
      cur <= next_cur;
    end
  end

  assign ready = (cur.st == ST_RUN);

endmodule : pcr_rst_ctrl

// *** logic/pcr_top.sv ***
// Pin configuration block with external reset and configuration registers
//
// Contract
// R01: One input-only pin, five configurable general pins
// R02: Inputs: plain, hysteresis, or low threshold
// R03: Push-pull or open-drain low/high, 1x/2x
// R04: Clock-capable pin may feed external clock
// R05: Optional pull-up/down of 10k, 100k, 1M
// R06: Unused pin gets 1M pull-down only
// R07: Pins high-impedance until power-on sequence ends
// R08: External reset spares configuration storage
// R09: External reset off, level or edge
// R10: Level mode holds reset while pin high
// R11: Level mode restarts sequence when pin low
// R12: Edge mode picks rising or falling edge
// R13: Qualifying edge resets and restarts sequence
// R14: Pin driven only while output enable set
`timescale 1ns/100ps
module pcr_top
  import pcr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Core side
  input  wire logic [NPIN-1:0]   core_out,
  input  wire logic [NPIN-1:0]   core_oe,
  output logic      [NPIN-1:0]   core_in,
  output logic                   ext_clk,
  output logic                   core_rst_n,
  // Pad side
  input  wire logic [NPIN-1:0]   pad_in,
  output logic      [NPIN-1:0]   pad_out,
  output logic      [NPIN-1:0]   pad_oe,
  output logic      [NPIN-1:0]   pad_pull_en,
  output logic      [NPIN-1:0]   pad_pull_up,
  output logic      [2*NPIN-1:0] pad_pull_val,
  output logic      [NPIN-1:0]   pad_drive2x,
  output logic      [2*NPIN-1:0] pad_in_style
);

  // Configuration lives only under the chip reset: the external reset
  // models a restart of logic, not a reload of stored settings.
  typedef struct packed {
    logic [NPIN-1:0][CFG_W-1:0] cfg;
    logic [RCFG_W-1:0]          rcfg;
    logic [DATA_W-1:0]          rdata;
  } pcr_top_s;

  pcr_top_s          cur;
  pcr_top_s          next_cur;
  logic              ready;
  logic              logic_rst_n;
  logic [NPIN-1:0]   cell_in;
  logic              clk_mode;
  logic [DATA_W-1:0] stat;

  // Reset sequencer
  pcr_rst_ctrl u_rst (
    .clk   (clk),
    .rst_n (rst_n),
    .gpi   (pad_in[PIN_IN]),
    .rcfg  (cur.rcfg),
    .ready (ready)
  );

  assign logic_rst_n = rst_n && ready; // R08
  assign core_rst_n  = ready;

  // Pad cells
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    pcr_pin_cell #(
      .INPUT_ONLY (i == PIN_IN) // R01
    ) u_cell (
      .clk      (clk),
      .rst_n    (logic_rst_n),
      .ready    (ready),
      .cfg      (cur.cfg[i]),
      .core_out (core_out[i]),
      .core_oe  (core_oe[i]),
      .core_in  (cell_in[i]),
      .pad_in   (pad_in[i]),
      .pad_out  (pad_out[i]),
      .pad_oe   (pad_oe[i]),
      .pull_en  (pad_pull_en[i]),
      .pull_up  (pad_pull_up[i]),
      .pull_val (pad_pull_val[2*i +: 2]),
      .drive2x  (pad_drive2x[i]),
      .in_style (pad_in_style[2*i +: 2])
    );
  end

  // Clock-capable pin steers its input to the clock net instead
  assign clk_mode = cur.cfg[PIN_CLK][F_CLK];
  always_comb begin
    core_in          = cell_in;
    core_in[PIN_CLK] = cell_in[PIN_CLK] && !clk_mode; // R04
  end
  assign ext_clk = cell_in[PIN_CLK] && clk_mode; // R04

  always_comb begin
    stat                   = '0;
    stat[S_READY]          = ready;
    stat[S_CLK]            = clk_mode;
    stat[S_IN +: NPIN]     = cell_in;
  end

  // Register file
  always_comb begin
    next_cur       = cur;
    next_cur.rdata = '0;
    if (wr) begin
      if (addr < REG_RST) begin
        next_cur.cfg[addr] = wdata[CFG_W-1:0];
      end else if (addr == REG_RST) begin
        next_cur.rcfg = wdata[RCFG_W-1:0]; // R09
      end
    end
    if (rd) begin
      if (addr < REG_RST) begin
        next_cur.rdata = DATA_W'(cur.cfg[addr]);
      end else if (addr == REG_RST) begin
        next_cur.rdata = DATA_W'(cur.rcfg);
      end else if (addr == REG_STAT) begin
        next_cur.rdata = stat;
      end else begin
        next_cur.rdata = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur.cfg   <= {NPIN{CFG_RST}}; // R06
      cur.rcfg  <= RCFG_RST;
      cur.rdata <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata = cur.rdata;

  // Checking helpers
  logic [CNT_W-1:0] low_run;
  logic [NPIN-1:0]  unused_ok;
  logic [NPIN-1:0]  od_ok;
  logic [NPIN-1:0]  oe_ok;
  logic             lvl;
  logic             edge_mode;
  logic             rise_sel;

  assign lvl       = pcr_rmode(cur.rcfg) == RM_LEVEL;
  assign edge_mode = pcr_rmode(cur.rcfg) == RM_EDGE;
  assign rise_sel  = cur.rcfg[F_REDGE];

  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      unused_ok[i] = (pcr_sel(cur.cfg[i]) != SEL_NONE) || !ready ||
                     (pad_pull_en[i] && !pad_pull_up[i] && !pad_oe[i] &&
                      pad_pull_val[2*i +: 2] == PV_1M);
      od_ok[i]     = !pad_oe[i] ||
                     (pcr_drv(cur.cfg[i]) != DRV_OD_LOW || !pad_out[i]) &&
                     (pcr_drv(cur.cfg[i]) != DRV_OD_HIGH || pad_out[i]);
      oe_ok[i]     = !pad_oe[i] || pcr_sel(cur.cfg[i]) == SEL_OUT ||
                     pcr_sel(cur.cfg[i]) == SEL_INOUT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || ready) begin
      low_run <= '0;
    end else if (low_run != CNT_MAX) begin
      low_run <= low_run + CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_hiz_before_ready: assert property (!ready |-> pad_oe == '0) // R07
    else $error("pad driven before power-on sequence ended");

  a_no_pull_early: assert property (!ready |-> pad_pull_en == '0) // R07
    else $error("pull resistor active before power-on sequence ended");

  a_unused_pin_pull: assert property (&unused_ok) // R06
    else $error("unused pin lacks 1M pull-down");

  a_input_only_quiet: assert property (!pad_oe[PIN_IN] && !pad_pull_up[PIN_IN]) // R01
    else $error("input-only pin driven or pulled up");

  a_open_drain_level: assert property (&od_ok) // R03
    else $error("open-drain pin drives the wrong level");

  a_oe_needs_output: assert property (&oe_ok) // R14
    else $error("pin driven while not an output");

  a_clk_pin_steer: assert property (clk_mode |-> !core_in[PIN_CLK]) // R04
    else $error("clock-capable pin leaks into core input in clock mode");

  a_level_hold: assert property (lvl && pad_in[PIN_IN] ##1 lvl |-> ##1 !core_rst_n) // R10
    else $error("level reset did not hold logic in reset");

  a_level_release: assert property (lvl && $rose(core_rst_n) |-> !$past(pad_in[PIN_IN], 2)) // R11
    else $error("logic left reset while level reset pin high");

  a_edge_restart: assert property (
    edge_mode && (rise_sel ? $rose(pad_in[PIN_IN]) : $fell(pad_in[PIN_IN])) ##1 edge_mode
    |-> ##1 !core_rst_n) // R12 R13
    else $error("qualifying edge did not restart reset sequence");

  a_seq_length: assert property ($rose(core_rst_n) |-> low_run >= POR_LAST) // R11
    else $error("power-on sequence shorter than required");

  a_off_no_reset: assert property (pcr_rmode(cur.rcfg) == RM_OFF && core_rst_n && !wr
    |=> core_rst_n) // R09
    else $error("logic reset while external reset disabled");

  a_cfg_survives: assert property (!core_rst_n && !wr |=> cur.cfg == $past(cur.cfg)) // R08
    else $error("configuration lost during external reset");

  c_level_hold: cover property (lvl && !core_rst_n ##1 core_rst_n);
  c_edge_restart: cover property (edge_mode && core_rst_n ##1 !core_rst_n);
  c_pin_driven: cover property (ready && pad_oe != '0);
  c_status_read: cover property (rd && addr == REG_STAT);

endmodule : pcr_top

// *** verif/pcr_board.sv ***
// Board model: pad levels from device drive, board drivers and pulls
`timescale 1ns/100ps
module pcr_board
  import pcr_pkg::*;
(
  // Clock
  input  wire logic            clk,
  // Device pad side
  input  wire logic [NPIN-1:0] pad_out,
  input  wire logic [NPIN-1:0] pad_oe,
  input  wire logic [NPIN-1:0] pad_pull_en,
  input  wire logic [NPIN-1:0] pad_pull_up,
  // Board drivers, bit 0 is the external reset source
  input  wire logic [NPIN-1:0] ext_en,
  input  wire logic [NPIN-1:0] ext_val,
  output logic      [NPIN-1:0] pad_in
);
  logic flip = 1'b0;

  // Floating pads wander so a stale level is never trusted
  always @(posedge clk) flip <= ~flip;

  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pull_en[i]) pad_in[i] = pad_pull_up[i];
      else pad_in[i] = flip ^ i[0];
    end
  end
endmodule : pcr_board

// *** verif/testbench.sv ***
// Self-checking bench for the pin configuration block
`timescale 1ns/100ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module testbench
  import pcr_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [NPIN-1:0]   core_out = '0;
  logic [NPIN-1:0]   core_oe = '0;
  logic [NPIN-1:0]   ext_en = 6'h01;
  logic [NPIN-1:0]   ext_val = '0;
  logic [DATA_W-1:0] rdata;
  logic [NPIN-1:0]   core_in, pad_in, pad_out, pad_oe, pad_pull_en, pad_pull_up, pad_drive2x;
  logic [2*NPIN-1:0] pad_pull_val, pad_in_style;
  logic              ext_clk, core_rst_n;
  logic [15:0]       seed = 16'h43a3;
  int                miscompares = 0;
  int                compares = 0;
  int                cycles = 0;

  always #5 clk = ~clk;

  pcr_top dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .core_out, .core_oe, .core_in,
    .ext_clk, .core_rst_n, .pad_in, .pad_out, .pad_oe, .pad_pull_en, .pad_pull_up,
    .pad_pull_val, .pad_drive2x, .pad_in_style);
  pcr_board board (.clk, .pad_out, .pad_oe, .pad_pull_en, .pad_pull_up, .ext_en, .ext_val,
    .pad_in);

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  function automatic logic [15:0] mk(input logic [1:0] sel, ins, drv, input logic str, pen,
                                     pup, input logic [1:0] pv);
    return {5'h00, pv, pup, pen, str, drv, ins, sel};
  endfunction : mk

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic results();
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Counts cycles until the logic reset lifts, checking the quiet pads on the way
  task automatic wait_ready(input int lo);
    int n;
    n = 0;
    while (core_rst_n !== 1'b1 && n < 300) begin
      settle(1);
      n++;
      if (n == 50) `CHK("held_pads", 0, {pad_oe, pad_pull_en});
    end
    `CHK("seq_len", 1, n >= lo && n <= lo + 6);
  endtask : wait_ready

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    logic [31:0] d;
    logic [15:0] r, c;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_ready(99);
    for (int a = 0; a < 7; a++) begin
      rd_reg(ADDR_W'(a), d);
      `CHK("rst_val", a < NPIN ? 32'(CFG_RST) : 32'h0000_0000, d);
    end
    rd_reg(4'h9, d);
    `CHK("unmapped", 0, d);
    rd_reg(REG_STAT, d);
    `CHK("ready", 1, d[S_READY]);
    `CHK("dflt_pull", {6'h3f, 6'h00, 12'haaa}, {pad_pull_en, pad_pull_up, pad_pull_val});
    for (int i = 1; i < NPIN; i++) begin
      r = rnd();
      c = mk(2'd2, 2'd0, 2'(i % 3), r[2], 1'b0, 1'b0, 2'd0);
      wr_reg(ADDR_W'(i), 32'(c));
      rd_reg(ADDR_W'(i), d);
      `CHK("cfg_rb", c, d);
      @(posedge clk);
      core_out <= r[15:10];
      settle(2);
      `CHK("drive2x", r[2], pad_drive2x[i]);
      if (i % 3 == 0) `CHK("pp_out", {1'b1, r[10 + i]}, {pad_oe[i], pad_out[i]});
      c = mk(2'd1, 2'(i % 3), 2'd0, 1'b0, 1'b1, r[3], 2'(i % 3));
      wr_reg(ADDR_W'(i), 32'(c));
      settle(5);
      `CHK("in_style", i % 3, pad_in_style[2*i +: 2]);
      `CHK("pull", {1'b1, r[3], 2'(i % 3)},
           {pad_pull_en[i], pad_pull_up[i], pad_pull_val[2*i +: 2]});
      `CHK("pulled_in", r[3], core_in[i]);
      @(posedge clk);
      ext_en[i] <= 1'b1;
      ext_val[i] <= r[4];
      settle(4);
      `CHK("core_in", r[4], core_in[i]);
      wr_reg(ADDR_W'(i), 32'(mk(2'd3, 2'd0, 2'd0, 1'b0, 1'b0, 1'b0, 2'd0)));
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        // Board lets go while the pin drives, avoiding contention
        ext_en[i] <= ~k[0];
        core_oe[i] <= k[0];
        settle(2);
        `CHK("oe_follow", k[0], pad_oe[i]);
      end
      @(posedge clk);
      core_oe[i] <= 1'b0;
      c = r & 16'h07fc;
      wr_reg(ADDR_W'(i), 32'(c));
      settle(2);
      `CHK("unused", 5'h0a, {pad_oe[i], pad_pull_en[i], pad_pull_up[i], pad_pull_val[2*i +: 2]});
    end
    wr_reg(ADDR_W'(PIN_CLK), 32'(mk(2'd1, 2'd0, 2'd0, 1'b0, 1'b0, 1'b0, 2'd0) | 16'h0800));
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      ext_en[1] <= 1'b1;
      ext_val[1] <= v[0];
      settle(3);
      `CHK("ext_clk", {v[0], 1'b0}, {ext_clk, core_in[1]});
    end
    @(posedge clk);
    ext_val[0] <= 1'b1;
    settle(5);
    `CHK("rst_off", 1, core_rst_n);
    wr_reg(REG_RST, 32'h0000_0001);
    settle(150);
    `CHK("lvl_hold", 0, core_rst_n);
    rd_reg(4'h5, d);
    `CHK("cfg_kept", c, d);
    @(posedge clk);
    ext_val[0] <= 1'b0;
    wait_ready(99);
    for (int e = 0; e < 2; e++) begin
      wr_reg(REG_RST, 32'h0000_0000);
      @(posedge clk);
      ext_val[0] <= e[0];
      wr_reg(REG_RST, {29'h0000_0000, e[0], 2'b10});
      @(posedge clk);
      ext_val[0] <= ~e[0];
      settle(5);
      `CHK("wrong_edge", 1, core_rst_n);
      @(posedge clk);
      ext_val[0] <= e[0];
      settle(3);
      `CHK("edge_rst", 0, core_rst_n);
      wait_ready(95);
    end
    results();
  end
endmodule : testbench
